// [rtl/spimsp_top.sv]
// design: byte-wide serial peripheral port, master or slave, with register port and interrupt
//
// Overview of operation
// - master write to data starts clock
// - written byte shifts out on mosi
// - after one byte stop clock, set done
// - done irq needs port and serial enables both, collision irq only its event enable
// - slave active only while select low
// - sck output as master, input as slave
// - port works only while enable bit set
// - order bit: 0 msb first, 1 lsb
// - role bit: 1 master, 0 slave
// - phase bit picks leading or trailing edge
// - master sck is clock over 4/16/64/128
// - rate bits ignored as slave
// - done flag sticky until software clears
// - data write while busy sets collision
// - control and status reset to zero
// - wake from idle only as slave
`timescale 1ns/1ps
module spimsp_top
    import spimsp_pkg::*;
#(
    parameter int HALF_DIV0 = SPIMSP_DIV_CODE0 / 2,
    parameter int HALF_DIV1 = SPIMSP_DIV_CODE1 / 2,
    parameter int HALF_DIV2 = SPIMSP_DIV_CODE2 / 2,
    parameter int HALF_DIV3 = SPIMSP_DIV_CODE3 / 2
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // register port
    input wire spimsp_bus_req_t i_bus,
    output logic [7:0] o_rdata,
    // system
    input wire logic i_cpu_idle,
    output logic o_wake,
    output logic o_irq,
    // serial pins
    input wire spimsp_pins_in_t i_pins,
    output spimsp_pins_out_t o_pins
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        spimsp_state_t st;
        logic [7:0] ctl;
        logic done;
        logic write_collision_flag;
        logic ser_irq_en;
        logic [1:0] ev_stat;
        logic [1:0] ev_en;
        logic [7:0] sh;
        logic [7:0] rxbuf;
        logic [6:0] div_cnt;
        logic [4:0] edge_cnt;
        logic [3:0] bit_cnt;
        logic sck_prev;
        logic ss_prev;
        logic [7:0] rdata;
        logic irq;
        logic wake;
        spimsp_pins_out_t pins;
    } spimsp_regs_t;

    spimsp_regs_t r_q, r_d;

    function automatic logic [6:0] half_period(input logic [1:0] code);
        case (code)
            2'b00: half_period = 7'(HALF_DIV0 - 1);
            2'b01: half_period = 7'(HALF_DIV1 - 1);
            2'b10: half_period = 7'(HALF_DIV2 - 1);
            default: half_period = 7'(HALF_DIV3 - 1);
        endcase
    endfunction : half_period

    function automatic logic out_bit(input logic [7:0] sh, input logic lsb_first);
        out_bit = lsb_first ? sh[0] : sh[7];
    endfunction : out_bit

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic lsb_first, input logic b);
        shift_in = lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : shift_in

    logic en, master, lsb_first, clock_polarity, clock_phase;
    logic data_wr, sel, lead_edge, trail_edge, drive_ev, sample_ev, rx_bit, finish, busy;

    assign en = r_q.ctl[SPIMSP_CTL_ENABLE_BIT];
    assign master = r_q.ctl[SPIMSP_CTL_ROLE_BIT];
    assign lsb_first = r_q.ctl[SPIMSP_CTL_ORDER_BIT];
    assign clock_polarity = r_q.ctl[SPIMSP_CTL_CLOCK_POLARITY_BIT];
    assign clock_phase = r_q.ctl[SPIMSP_CTL_CLOCK_PHASE_BIT];
    assign data_wr = i_bus.wr && i_bus.addr == SPIMSP_DATA_OFS;
    assign sel = en && !master && !i_pins.ss_n;
    assign busy = r_q.st != SPIMSP_ST_IDLE || (sel && r_q.bit_cnt != 4'd0);

    always_comb begin
        r_d = r_q;
        lead_edge = 1'b0;
        trail_edge = 1'b0;
        rx_bit = master ? i_pins.miso : i_pins.mosi;
        finish = 1'b0;
        r_d.sck_prev = i_pins.sck;
        r_d.ss_prev = i_pins.ss_n;

        // ----------------------------------------
        // edge generation
        // ----------------------------------------
        case (r_q.st)
            SPIMSP_ST_IDLE: begin
                if (sel) begin
                    r_d.st = SPIMSP_ST_SLAVE;
                end
            end
            SPIMSP_ST_MASTER: begin
                if (!en || !master) begin
                    r_d.st = SPIMSP_ST_IDLE;
                end else if (r_q.div_cnt == 7'd0) begin
                    r_d.div_cnt = half_period(r_q.ctl[1:0]);
                    r_d.pins.sck = ~r_q.pins.sck;
                    lead_edge = !r_q.edge_cnt[0];
                    trail_edge = r_q.edge_cnt[0];
                    r_d.edge_cnt = r_q.edge_cnt + 5'd1;
                end else begin
                    r_d.div_cnt = r_q.div_cnt - 7'd1;
                end
            end
            SPIMSP_ST_SLAVE: begin
                if (!sel) begin
                    r_d.st = SPIMSP_ST_IDLE;
                    r_d.bit_cnt = 4'd0;
                end else if (i_pins.sck != r_q.sck_prev) begin
                    // rate bits unused here: timing comes from the far master
                    lead_edge = r_q.sck_prev == clock_polarity;
                    trail_edge = r_q.sck_prev != clock_polarity;
                end
            end
            default: r_d.st = SPIMSP_ST_IDLE;
        endcase

        // ----------------------------------------
        // shifting
        // ----------------------------------------
        drive_ev = clock_phase ? lead_edge : trail_edge;
        sample_ev = clock_phase ? trail_edge : lead_edge;
        if (drive_ev) begin
            r_d.pins.mosi = out_bit(r_q.sh, lsb_first);
            r_d.pins.miso = out_bit(r_q.sh, lsb_first);
        end
        if (sample_ev) begin
            r_d.sh = shift_in(r_q.sh, lsb_first, rx_bit);
            if (r_q.st == SPIMSP_ST_SLAVE) begin
                r_d.bit_cnt = r_q.bit_cnt + 4'd1;
                finish = r_q.bit_cnt == 4'(SPIMSP_BITS_PER_BYTE - 1);
                if (finish) begin
                    r_d.bit_cnt = 4'd0;
                end
            end
        end
        if (r_q.st == SPIMSP_ST_MASTER && trail_edge
            && r_q.edge_cnt == 5'(SPIMSP_EDGES_PER_BYTE - 1)) begin
            finish = 1'b1;
            r_d.st = SPIMSP_ST_IDLE;
        end
        // slave phase 0: first bit must be on the line as soon as select falls
        if (sel && r_q.ss_prev && !clock_phase) begin
            r_d.pins.miso = out_bit(r_q.sh, lsb_first);
        end
        if (finish) begin
            r_d.rxbuf = r_d.sh;
        end

        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (data_wr) begin
            if (busy) begin
                r_d.write_collision_flag = 1'b1;
            end else begin
                r_d.sh = i_bus.wdata;
                if (en && master) begin
                    r_d.st = SPIMSP_ST_MASTER;
                    r_d.div_cnt = half_period(r_q.ctl[1:0]);
                    r_d.edge_cnt = 5'd0;
                    r_d.pins.mosi = out_bit(i_bus.wdata, lsb_first);
                end else if (!clock_phase) begin
                    r_d.pins.miso = out_bit(i_bus.wdata, lsb_first);
                end
            end
        end
        if (i_bus.wr) begin
            case (i_bus.addr)
                SPIMSP_CONTROL_OFS: r_d.ctl = i_bus.wdata;
                SPIMSP_AUX_OFS: r_d.ser_irq_en = i_bus.wdata[SPIMSP_AUX_SER_IRQ_EN_BIT];
                SPIMSP_IRQ_EN_OFS: r_d.ev_en = i_bus.wdata[1:0];
                SPIMSP_STATUS_OFS: begin
                    if (i_bus.wdata[SPIMSP_STS_DONE_BIT]) begin
                        r_d.done = 1'b0;
                    end
                    if (i_bus.wdata[SPIMSP_STS_WRITE_COLLISION_FLAG_BIT]) begin
                        r_d.write_collision_flag = data_wr && busy;
                    end
                end
                SPIMSP_IRQ_CLR_OFS: r_d.ev_stat = r_q.ev_stat & ~i_bus.wdata[1:0];
                default: ;
            endcase
        end
        // set beats clear
        if (finish) begin
            r_d.done = 1'b1;
            r_d.ev_stat[SPIMSP_EV_DONE] = 1'b1;
        end
        if (data_wr && busy) begin
            r_d.ev_stat[SPIMSP_EV_WRITE_COLLISION_FLAG] = 1'b1;
        end

        // ----------------------------------------
        // pins, interrupt, wake, read data
        // ----------------------------------------
        if (r_d.st != SPIMSP_ST_MASTER) begin
            r_d.pins.sck = r_d.ctl[SPIMSP_CTL_CLOCK_POLARITY_BIT];
        end
        r_d.pins.sck_oe = r_d.ctl[SPIMSP_CTL_ENABLE_BIT] && r_d.ctl[SPIMSP_CTL_ROLE_BIT];
        r_d.pins.mosi_oe = r_d.pins.sck_oe;
        r_d.pins.miso_oe = r_d.ctl[SPIMSP_CTL_ENABLE_BIT] && !r_d.ctl[SPIMSP_CTL_ROLE_BIT]
            && !i_pins.ss_n;
        r_d.irq = (r_d.ev_stat[SPIMSP_EV_DONE] && r_d.ev_en[SPIMSP_EV_DONE]
                   && r_d.ctl[SPIMSP_CTL_IRQ_EN_BIT] && r_d.ser_irq_en)
            || (r_d.ev_stat[SPIMSP_EV_WRITE_COLLISION_FLAG] && r_d.ev_en[SPIMSP_EV_WRITE_COLLISION_FLAG]);
        if (!i_cpu_idle) begin
            r_d.wake = 1'b0;
        end else if (finish && r_q.st == SPIMSP_ST_SLAVE) begin
            r_d.wake = 1'b1;
        end
        r_d.rdata = 8'h00;
        if (i_bus.rd) begin
            case (i_bus.addr)
                SPIMSP_CONTROL_OFS: r_d.rdata = r_q.ctl;
                SPIMSP_STATUS_OFS: r_d.rdata = {r_q.done, r_q.write_collision_flag, 6'h00};
                SPIMSP_DATA_OFS: r_d.rdata = r_q.rxbuf;
                SPIMSP_AUX_OFS: r_d.rdata = {7'h00, r_q.ser_irq_en};
                SPIMSP_IRQ_STAT_OFS: r_d.rdata = {6'h00, r_q.ev_stat};
                SPIMSP_IRQ_EN_OFS: r_d.rdata = {6'h00, r_q.ev_en};
                default: r_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r_q <= '0;
            r_q.st <= SPIMSP_ST_IDLE;
            r_q.ctl <= SPIMSP_CONTROL_RST;
            r_q.done <= SPIMSP_STATUS_RST[SPIMSP_STS_DONE_BIT];
            r_q.write_collision_flag <= SPIMSP_STATUS_RST[SPIMSP_STS_WRITE_COLLISION_FLAG_BIT];
            r_q.sck_prev <= 1'b0;
            r_q.ss_prev <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_rdata = r_q.rdata;
    assign o_irq = r_q.irq;
    assign o_wake = r_q.wake;
    assign o_pins = r_q.pins;
endmodule : spimsp_top

// [shared/spimsp_pkg.sv]
// package: register map, field layout and timing for the serial peripheral port
package spimsp_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] SPIMSP_STATUS_OFS = 8'haa;
    localparam logic [7:0] SPIMSP_CONTROL_OFS = 8'hd5;
    localparam logic [7:0] SPIMSP_DATA_OFS = 8'h86;
    localparam logic [7:0] SPIMSP_AUX_OFS = 8'he3;
    localparam logic [7:0] SPIMSP_IRQ_STAT_OFS = 8'he0;
    localparam logic [7:0] SPIMSP_IRQ_EN_OFS = 8'he1;
    localparam logic [7:0] SPIMSP_IRQ_CLR_OFS = 8'he2;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int SPIMSP_CTL_IRQ_EN_BIT = 7;
    localparam int SPIMSP_CTL_ENABLE_BIT = 6;
    localparam int SPIMSP_CTL_ORDER_BIT = 5;
    localparam int SPIMSP_CTL_ROLE_BIT = 4;
    localparam int SPIMSP_CTL_CLOCK_POLARITY_BIT = 3;
    localparam int SPIMSP_CTL_CLOCK_PHASE_BIT = 2;
    localparam int SPIMSP_STS_DONE_BIT = 7;
    localparam int SPIMSP_STS_WRITE_COLLISION_FLAG_BIT = 6;
    localparam int SPIMSP_AUX_SER_IRQ_EN_BIT = 0;
    localparam int SPIMSP_EV_DONE = 0;
    localparam int SPIMSP_EV_WRITE_COLLISION_FLAG = 1;
    localparam logic [7:0] SPIMSP_CONTROL_RST = 8'h00;
    localparam logic [7:0] SPIMSP_STATUS_RST = 8'h00;

    // ----------------------------------------
    // timing: full sck period in clocks per rate code (divide by 4/16/64/128)
    // ----------------------------------------
    localparam int SPIMSP_DIV_CODE0 = 4;
    localparam int SPIMSP_DIV_CODE1 = 16;
    localparam int SPIMSP_DIV_CODE2 = 64;
    localparam int SPIMSP_DIV_CODE3 = 128;
    localparam int SPIMSP_EDGES_PER_BYTE = 16;
    localparam int SPIMSP_BITS_PER_BYTE = 8;

    typedef enum logic [2:0] {
        SPIMSP_ST_IDLE = 3'b001,
        SPIMSP_ST_MASTER = 3'b010,
        SPIMSP_ST_SLAVE = 3'b100
    } spimsp_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spimsp_bus_req_t;

    typedef struct packed {
        logic sck;
        logic ss_n;
        logic mosi;
        logic miso;
    } spimsp_pins_in_t;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic mosi;
        logic mosi_oe;
        logic miso;
        logic miso_oe;
    } spimsp_pins_out_t;
endpackage : spimsp_pkg

// [testbench/spimsp_checker.sv]
// checker: register port, pin enable and interrupt relations of the serial port
`timescale 1ns/1ps
module spimsp_checker
    import spimsp_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // bus and system
    input wire spimsp_bus_req_t i_bus,
    input wire logic [7:0] o_rdata,
    input wire logic i_cpu_idle,
    input wire logic o_wake,
    input wire logic o_irq,
    // pins
    input wire spimsp_pins_in_t i_pins,
    input wire spimsp_pins_out_t o_pins
);
    logic [7:0] ctl_q;
    logic [7:0] ien_q;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctl_q <= 8'h00;
            ien_q <= 8'h00;
        end else if (i_bus.wr) begin
            if (i_bus.addr == SPIMSP_CONTROL_OFS) ctl_q <= i_bus.wdata;
            if (i_bus.addr == SPIMSP_IRQ_EN_OFS) ien_q <= i_bus.wdata;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_status_rsvd: assert property ($past(i_bus.rd && i_bus.addr == SPIMSP_STATUS_OFS)
        |-> o_rdata[5:0] == 6'h00) else $error("status reserved bits set");
    a_ctl_readback: assert property ($past(i_bus.rd && i_bus.addr == SPIMSP_CONTROL_OFS)
        |-> o_rdata == $past(ctl_q)) else $error("control readback wrong");
    a_sck_oe_role: assert property (o_pins.sck_oe
        |-> (ctl_q[6] && ctl_q[4]) || $past(ctl_q[6] && ctl_q[4])) else $error("sck driven outside master");
    a_oe_pair: assert property (o_pins.mosi_oe == o_pins.sck_oe) else $error("mosi and sck enables differ");
    a_miso_sel: assert property (o_pins.miso_oe |-> !$past(i_pins.ss_n) && !o_pins.sck_oe)
        else $error("miso driven unselected");
    a_sck_hold: assert property (o_pins.sck_oe && $changed(o_pins.sck) |=> $stable(o_pins.sck))
        else $error("sck half period too short");
    a_irq_gate: assert property (o_irq |-> ien_q != 8'h00 || $past(ien_q, 2) != 8'h00)
        else $error("irq without enable");
    a_wake_clear: assert property (!i_cpu_idle |=> !o_wake) else $error("wake outside idle");
endmodule : spimsp_checker

// [testbench/spimsp_slave_model.sv]
// partner: behavioural spi slave answering the port in master role
`timescale 1ns/1ps
module spimsp_slave_model
    import spimsp_pkg::*;
(
    // clock and pins
    input wire logic i_clk,
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_ss_n,
    // mode and data
    input wire logic [7:0] i_ctl,
    input wire logic [7:0] i_tx,
    output logic o_miso,
    output logic [7:0] o_rx
);
    logic sck_q = 1'b0;
    logic lead;
    int idx = 0;
    initial o_miso = 1'b0;
    assign lead = (i_sck != i_ctl[SPIMSP_CTL_CLOCK_POLARITY_BIT]);
    always @(posedge i_clk) begin
        sck_q <= i_sck;
        if (i_ss_n) begin
            idx <= 0;
            // released line: no stable level for the port to rely on
            o_miso <= ~o_miso;
        end else if (i_sck != sck_q && lead != i_ctl[SPIMSP_CTL_CLOCK_PHASE_BIT]) begin
            o_rx <= i_ctl[SPIMSP_CTL_ORDER_BIT] ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
        end else if (i_sck != sck_q || (idx == 0 && !i_ctl[SPIMSP_CTL_CLOCK_PHASE_BIT])) begin
            idx <= idx + 1;
            o_miso <= (idx > 7) ? ~o_miso : i_tx[i_ctl[SPIMSP_CTL_ORDER_BIT] ? idx : 7 - idx];
        end
    end
endmodule : spimsp_slave_model

// [testbench/spimsp_top_tb.sv]
// testbench: register port, master rows, collision, interrupt and slave cases
`timescale 1ns/1ps
module spimsp_top_tb
    import spimsp_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic idle = 1'b0;
    logic ss_n = 1'b1;
    logic bsck = 1'b0;
    logic bmosi = 1'b0;
    logic smiso, wake, irq;
    logic [7:0] ctl = 8'h00;
    logic [7:0] stx = 8'h00;
    logic [7:0] rdata, srx, rv, mv;
    spimsp_bus_req_t bus = '0;
    spimsp_pins_in_t pin_i;
    spimsp_pins_out_t pin_o;
    int errors = 0;
    int compares = 0;
    int i, b;
    // byte the bench shifts into the port when it plays master
    localparam logic [7:0] SLV_RX = 8'hd2;
    // ctl, tx byte, partner byte: every mode, order and rate code
    logic [23:0] rows [5] = '{24'h50a53c, 24'h7c96e1, 24'h590ff0, 24'h56817e, 24'h73c35a};
    always #5 clk = ~clk;
    assign pin_i = '{sck: pin_o.sck_oe ? pin_o.sck : bsck, ss_n: ss_n,
        mosi: pin_o.mosi_oe ? pin_o.mosi : bmosi, miso: pin_o.miso_oe ? pin_o.miso : smiso};
    spimsp_top i_dut (.i_clk(clk), .i_nrst(nrst), .i_bus(bus), .o_rdata(rdata), .i_cpu_idle(idle),
        .o_wake(wake), .o_irq(irq), .i_pins(pin_i), .o_pins(pin_o));
    spimsp_slave_model i_peer (.i_clk(clk), .i_sck(pin_i.sck), .i_mosi(pin_i.mosi), .i_ss_n(ss_n),
        .i_ctl(ctl), .i_tx(stx), .o_miso(smiso), .o_rx(srx));
    // ----------------------------------------
    // bus tasks and comparison
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        v = rdata;
        @(posedge clk);
    endtask : rd
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wait_done(output logic [7:0] st);
        for (int k = 0; k < 600; k++) begin
            rd(SPIMSP_STATUS_OFS, st);
            if (st[7] === 1'b1) break;
        end
    endtask : wait_done
    task automatic conclude();
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        #200us;
        errors++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(SPIMSP_CONTROL_OFS, rv);
        chk("ctl reset", rv, 8'h00);
        rd(SPIMSP_STATUS_OFS, rv);
        chk("sts reset", rv, 8'h00);
        rd(8'h00, rv);
        chk("unmapped", rv, 8'h00);
        for (i = 0; i < 5; i++) begin
            ctl <= rows[i][23:16];
            stx <= rows[i][7:0];
            wr(SPIMSP_CONTROL_OFS, rows[i][23:16]);
            ss_n <= 1'b0;
            wr(SPIMSP_DATA_OFS, rows[i][15:8]);
            wait_done(rv);
            chk("done", rv, 8'h80);
            chk("sck idle", {7'h00, pin_o.sck}, {7'h00, ctl[3]});
            rd(SPIMSP_DATA_OFS, rv);
            chk("rx byte", rv, stx);
            chk("peer rx", srx, rows[i][15:8]);
            wr(SPIMSP_STATUS_OFS, 8'h80);
            ss_n <= 1'b1;
        end
        // mid-transfer write: flag set, shifting byte untouched
        ctl <= 8'h50;
        wr(SPIMSP_IRQ_EN_OFS, 8'h02);
        wr(SPIMSP_CONTROL_OFS, 8'h50);
        ss_n <= 1'b0;
        wr(SPIMSP_DATA_OFS, 8'h3c);
        wr(SPIMSP_DATA_OFS, 8'hff);
        wait_done(rv);
        chk("write_collision_flag", rv, 8'hc0);
        chk("irq write_collision_flag", {7'h00, irq}, 8'h01);
        chk("kept", srx, 8'h3c);
        wr(SPIMSP_IRQ_CLR_OFS, 8'hff);
        wr(SPIMSP_STATUS_OFS, 8'hc0);
        chk("irq clr", {7'h00, irq}, 8'h00);
        wr(SPIMSP_IRQ_EN_OFS, 8'h01);
        wr(SPIMSP_CONTROL_OFS, 8'hd0);
        wr(SPIMSP_DATA_OFS, 8'h11);
        wait_done(rv);
        chk("irq no aux", {7'h00, irq}, 8'h00);
        wr(SPIMSP_AUX_OFS, 8'h01);
        chk("irq on", {7'h00, irq}, 8'h01);
        wr(SPIMSP_IRQ_EN_OFS, 8'h00);
        chk("irq mask", {7'h00, irq}, 8'h00);
        wr(SPIMSP_STATUS_OFS, 8'hc0);
        ss_n <= 1'b1;
        wr(SPIMSP_CONTROL_OFS, 8'h10);
        wr(SPIMSP_DATA_OFS, 8'h22);
        repeat (100) @(posedge clk);
        rd(SPIMSP_STATUS_OFS, rv);
        chk("disabled", rv, 8'h00);
        chk("sck oe off", {7'h00, pin_o.sck_oe}, 8'h00);
        // slave role with rate bits set, bench is the master
        idle <= 1'b1;
        wr(SPIMSP_CONTROL_OFS, 8'h43);
        wr(SPIMSP_DATA_OFS, 8'h6b);
        ss_n <= 1'b0;
        for (b = 7; b >= 0; b--) begin
            bmosi <= SLV_RX[b];
            repeat (6) @(posedge clk);
            mv = {mv[6:0], pin_o.miso};
            repeat (2) @(posedge clk);
            bsck <= 1'b1;
            repeat (8) @(posedge clk);
            bsck <= 1'b0;
        end
        repeat (8) @(posedge clk);
        chk("slave tx", mv, 8'h6b);
        rd(SPIMSP_DATA_OFS, rv);
        chk("slave rx", rv, SLV_RX);
        rd(SPIMSP_STATUS_OFS, rv);
        chk("slave done", rv, 8'h80);
        chk("wake", {7'h00, wake}, 8'h01);
        idle <= 1'b0;
        ss_n <= 1'b1;
        repeat (2) @(posedge clk);
        // mid-run reset: done flag and control are set here, both must drop
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(SPIMSP_CONTROL_OFS, rv);
        chk("ctl rerst", rv, 8'h00);
        rd(SPIMSP_STATUS_OFS, rv);
        chk("sts rerst", rv, 8'h00);
        conclude();
    end
endmodule : spimsp_top_tb
bind spimsp_top spimsp_checker i_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_cpu_idle(i_cpu_idle), .o_wake(o_wake), .o_irq(o_irq), .i_pins(i_pins), .o_pins(o_pins));
